// file: hdl/stm_core.v
// standard timer operating modes with register port
`timescale 1ns/100ps
`default_nettype none
`include "stm_map.vh"
module stm_core (
  input wire i_core_clk,
  input wire i_resetn,
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire i_external_clock_pin,
  output reg [7:0] o_rdata,
  output reg o_waveform,
  output reg o_waveform_oe
);
  reg [7:0] ctrl0_q;
  reg [7:0] ctrl1_q;
  reg [15:0] compare_a_value_q;
  reg [7:0] period_compare_value_q;
  reg [7:0] presc_q;
  reg [15:0] cnt_q;
  reg run_enable_q;
  reg run_prev_q;
  reg compare_a_match_flag_q;
  reg compare_p_match_flag_q;
  reg pin_q;
  wire tick;
  wire ext_edge;
  wire [1:0] mode_w;
  wire [1:0] pin_func_w;
  wire clear_source_select;
  wire duty_period_swap;
  wire output_initial_level;
  wire output_invert;
  wire is_pwm;
  wire is_single;
  wire is_cmp;
  wire run_rise;
  wire match_a;
  wire match_p;
  wire [16:0] per_a;
  wire [16:0] per_p;
  wire [16:0] period_w;
  wire [16:0] duty_w;
  wire pwm_active;
  reg [15:0] cnt_d;
  reg clr_w;
  reg set_a;
  reg set_p;

  // scale an 8-bit period value to clocks, zero meaning the full 65536
  function [16:0] scale_p;
    input [7:0] v;
    begin
      scale_p = (v == 8'h00) ? 17'h10000 : {1'b0, v, 8'h00};
    end
  endfunction

  assign mode_w = {ctrl1_q[`STM_C1_M1], ctrl1_q[`STM_C1_M0]};
  assign pin_func_w = {ctrl1_q[`STM_C1_IO1], ctrl1_q[`STM_C1_IO0]};
  assign clear_source_select = ctrl1_q[`STM_C1_CCLR];
  assign duty_period_swap = ctrl1_q[`STM_C1_DPX];
  assign output_initial_level = ctrl1_q[`STM_C1_OC];
  assign output_invert = ctrl1_q[`STM_C1_POL];
  assign is_pwm = (mode_w == `STM_MODE_PWM) && (pin_func_w != `STM_IO_ONE);
  assign is_single = (mode_w == `STM_MODE_PWM) && (pin_func_w == `STM_IO_ONE);
  // compare mode and timer mode share counting
  assign is_cmp = (mode_w == `STM_MODE_CMP) || (mode_w == `STM_MODE_TMR);
  assign run_rise = run_enable_q & ~run_prev_q;

  assign match_a = tick && run_enable_q && (compare_a_value_q != 16'h0000) &&
                   (cnt_q == compare_a_value_q);
  // period compared with the upper byte; match on the last count so the
  // clear lands exactly on a multiple of 256 ticks
  assign match_p = tick && run_enable_q && (period_compare_value_q != 8'h00) &&
                   (cnt_q[15:8] == (period_compare_value_q - 8'h01)) &&
                   (cnt_q[7:0] == 8'hFF);

  assign per_a = {1'b0, compare_a_value_q};
  assign per_p = scale_p(period_compare_value_q);
  assign period_w = duty_period_swap ? per_a : per_p;
  assign duty_w = duty_period_swap ? per_p : per_a;
  // duty at or beyond period stays active
  assign pwm_active = ({1'b0, cnt_q} < duty_w) || (duty_w >= period_w);

  stm_tick_gen u_tick (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_presc(presc_q),
    .i_ext_sel(ctrl0_q[`STM_C0_EXTSEL]),
    .i_ext_fall(ctrl0_q[`STM_C0_EXTFALL]),
    .i_ext_pin(i_external_clock_pin),
    .o_tick(tick),
    .o_ext_edge(ext_edge)
  );

  // next counter value and flag events per mode
  always @* begin
    cnt_d = cnt_q;
    clr_w = 1'b0;
    set_a = 1'b0;
    set_p = 1'b0;
    if (is_pwm) begin
      // clear by the period source, flag each match
      set_a = match_a;
      set_p = match_p;
      clr_w = duty_period_swap ? match_a :
              (match_p || (period_compare_value_q == 8'h00 && cnt_q == `STM_CNT_MAX));
    end else if (is_single) begin
      // only A matters; no clearing while running
      set_a = match_a;
    end else if (clear_source_select) begin
      // clear on A, P flag suppressed
      set_a = match_a;
      clr_w = match_a;
    end else begin
      // clear on P or overflow, both flags
      set_a = match_a;
      set_p = match_p;
      clr_w = match_p || (period_compare_value_q == 8'h00 && cnt_q == `STM_CNT_MAX);
    end
    if (run_rise) begin
      cnt_d = 16'h0000;
    end else if (tick && run_enable_q) begin
      if (clr_w) begin
        cnt_d = 16'h0000;
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
  end

  always @(posedge i_core_clk) begin
    if (!i_resetn) begin
      ctrl0_q <= `STM_RST_BYTE;
      ctrl1_q <= `STM_RST_BYTE;
      compare_a_value_q <= 16'h0000;
      period_compare_value_q <= `STM_RST_BYTE;
      presc_q <= `STM_RST_PRESC;
      cnt_q <= 16'h0000;
      run_enable_q <= 1'b0;
      run_prev_q <= 1'b0;
      compare_a_match_flag_q <= 1'b0;
      compare_p_match_flag_q <= 1'b0;
      pin_q <= 1'b0;
      o_rdata <= 8'h00;
    end else begin
      run_prev_q <= run_enable_q;
      cnt_q <= cnt_d;
      if (i_wr) begin
        case (i_addr)
          `STM_OFF_CTRL0: ctrl0_q <= i_wdata;
          `STM_OFF_CTRL1: ctrl1_q <= i_wdata;
          `STM_OFF_COMPARE_A_VALUE_L: compare_a_value_q[7:0] <= i_wdata;
          `STM_OFF_COMPARE_A_VALUE_H: compare_a_value_q[15:8] <= i_wdata;
          `STM_OFF_PERIOD_COMPARE_VALUE: period_compare_value_q <= i_wdata;
          `STM_OFF_PRESC: presc_q <= i_wdata;
          default: ;
        endcase
      end
      // run-enable: software write, then hardware set/clear take priority
      if (i_wr && i_addr == `STM_OFF_CTRL0) begin
        run_enable_q <= i_wdata[`STM_C0_RUN];
      end
      // external edge auto-starts in single pulse
      if (is_single && ext_edge) begin
        run_enable_q <= 1'b1;
      end
      if (is_single && match_a) begin
        run_enable_q <= 1'b0;
      end
      // sticky flags, write one clears, a new event wins
      if (i_wr && i_addr == `STM_OFF_FLAGS) begin
        if (i_wdata[`STM_FLG_A]) compare_a_match_flag_q <= 1'b0;
        if (i_wdata[`STM_FLG_P]) compare_p_match_flag_q <= 1'b0;
      end
      if (set_a) compare_a_match_flag_q <= 1'b1;
      if (set_p) compare_p_match_flag_q <= 1'b1;
      // compare-mode pin state
      if (run_rise) begin
        pin_q <= output_initial_level;
      end else if (set_a) begin
        // only A match moves the pin
        case (pin_func_w)
          `STM_IO_LOW: pin_q <= 1'b0;
          `STM_IO_HIGH: pin_q <= 1'b1;
          `STM_IO_ONE: pin_q <= ~pin_q;
          default: pin_q <= pin_q;
        endcase
      end
      o_rdata <= 8'h00;
      if (i_rd) begin
        case (i_addr)
          `STM_OFF_CTRL0: o_rdata <= {ctrl0_q[7:4], run_enable_q, 3'h0};
          `STM_OFF_CTRL1: o_rdata <= ctrl1_q;
          `STM_OFF_COMPARE_A_VALUE_L: o_rdata <= compare_a_value_q[7:0];
          `STM_OFF_COMPARE_A_VALUE_H: o_rdata <= compare_a_value_q[15:8];
          `STM_OFF_PERIOD_COMPARE_VALUE: o_rdata <= period_compare_value_q;
          `STM_OFF_CNT_L: o_rdata <= cnt_q[7:0];
          `STM_OFF_CNT_H: o_rdata <= cnt_q[15:8];
          `STM_OFF_FLAGS: o_rdata <= {6'h00, compare_p_match_flag_q, compare_a_match_flag_q};
          `STM_OFF_PRESC: o_rdata <= presc_q;
          default: o_rdata <= 8'h00;
        endcase
      end
    end
  end

  // output pin; registered, so it trails internal state by one cycle
  always @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_waveform <= 1'b0;
      o_waveform_oe <= 1'b0;
    end else begin
      // timer mode leaves the pin undriven
      o_waveform_oe <= (mode_w != `STM_MODE_TMR) && (mode_w != 2'h1);
      if (is_pwm) begin
        // force or waveform, then active level and invert
        case (pin_func_w)
          2'h0: o_waveform <= ~output_initial_level ^ output_invert;
          2'h1: o_waveform <= output_initial_level ^ output_invert;
          default: o_waveform <= (run_enable_q && pwm_active ?
                                  output_initial_level : ~output_initial_level)
                                 ^ output_invert;
        endcase
      end else if (is_single) begin
        o_waveform <= (run_enable_q ? output_initial_level : ~output_initial_level)
                      ^ output_invert;
      end else if (is_cmp) begin
        o_waveform <= pin_q ^ output_invert;
      end else begin
        o_waveform <= 1'b0;
      end
    end
  end
endmodule // stm_core
`default_nettype wire

// file: hdl/stm_map.vh
// constants for the standard timer: register offsets, fields, reset values
`ifndef STM_MAP_VH
`define STM_MAP_VH
`define STM_ADDR_W 4
`define STM_OFF_CTRL0 4'h0
`define STM_OFF_CTRL1 4'h1
`define STM_OFF_COMPARE_A_VALUE_L 4'h2
`define STM_OFF_COMPARE_A_VALUE_H 4'h3
`define STM_OFF_PERIOD_COMPARE_VALUE 4'h4
`define STM_OFF_CNT_L 4'h5
`define STM_OFF_CNT_H 4'h6
`define STM_OFF_FLAGS 4'h7
`define STM_OFF_PRESC 4'h8
`define STM_C0_RUN 3
`define STM_C0_EXTSEL 4
`define STM_C0_EXTFALL 5
`define STM_C1_M1 7
`define STM_C1_M0 6
`define STM_C1_IO1 5
`define STM_C1_IO0 4
`define STM_C1_OC 3
`define STM_C1_POL 2
`define STM_C1_DPX 1
`define STM_C1_CCLR 0
`define STM_FLG_A 0
`define STM_FLG_P 1
`define STM_MODE_CMP 2'h0
`define STM_MODE_PWM 2'h2
`define STM_MODE_TMR 2'h3
`define STM_IO_PWM 2'h2
`define STM_IO_ONE 2'h3
`define STM_IO_LOW 2'h1
`define STM_IO_HIGH 2'h2
`define STM_RST_BYTE 8'h00
`define STM_RST_PRESC 8'h00
`define STM_CNT_MAX 16'hFFFF
`endif

// file: hdl/stm_tick_gen.v
// timer clock enable: internal divider or external pin edge
`timescale 1ns/100ps
`default_nettype none
module stm_tick_gen (
  input wire i_core_clk,
  input wire i_resetn,
  input wire [7:0] i_presc,
  input wire i_ext_sel,
  input wire i_ext_fall,
  input wire i_ext_pin,
  output reg o_tick,
  output reg o_ext_edge
);
  reg [7:0] div_q;
  reg pin_q;
  wire edge_w;
  // selected active edge of the external pin
  assign edge_w = i_ext_fall ? (pin_q & ~i_ext_pin) : (~pin_q & i_ext_pin);
  always @(posedge i_core_clk) begin
    if (!i_resetn) begin
      div_q <= 8'h00;
      pin_q <= 1'b0;
      o_tick <= 1'b0;
      o_ext_edge <= 1'b0;
    end else begin
      pin_q <= i_ext_pin;
      o_ext_edge <= edge_w;
      if (div_q >= i_presc) begin
        div_q <= 8'h00;
      end else begin
        div_q <= div_q + 8'h01;
      end
      // prescale 0 gives one tick per core cycle
      o_tick <= i_ext_sel ? edge_w : (div_q >= i_presc);
    end
  end
endmodule // stm_tick_gen
`default_nettype wire

// file: test/stm_core_asserts.sv
// port checker for the standard timer
`timescale 1ns/100ps
`default_nettype none
module stm_core_asserts (
  input wire i_core_clk,
  input wire i_resetn,
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire i_external_clock_pin,
  input wire [7:0] o_rdata,
  input wire o_waveform,
  input wire o_waveform_oe
);
  reg [7:0] c1_q;
  reg [1:0] age_q;
  wire ok = age_q == 2'h3;
  wire [1:0] md = c1_q[7:6];
  wire [1:0] io = c1_q[5:4];
  // control writes need a few cycles to reach the pin
  always @(posedge i_core_clk) begin
    if (!i_resetn) begin
      c1_q <= 8'h00;
      age_q <= 2'h0;
    end else begin
      if (i_wr && i_addr == 4'h1) c1_q <= i_wdata;
      if (i_wr && i_addr < 4'h2) age_q <= 2'h0;
      else if (!ok) age_q <= age_q + 2'h1;
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not idle");
  unmapped_read_a: assert property (i_rd && i_addr > 4'h8 |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  flag_bits_a: assert property (i_rd && i_addr == 4'h7 |=> o_rdata[7:2] == 6'h00)
    else $error("flag byte high bits set");
  ctrl_readback_a: assert property (i_rd && i_addr == 4'h1 |=> o_rdata == c1_q)
    else $error("control readback wrong");
  timer_no_pin_a: assert property (ok && md == 2'h3 |-> !o_waveform_oe)
    else $error("pin driven in timer mode");
  cmp_drive_a: assert property (ok && md == 2'h0 |-> o_waveform_oe)
    else $error("pin not driven in compare mode");
  cmp_hold_a: assert property (ok && md == 2'h0 && io == 2'h0 |-> $stable(o_waveform))
    else $error("pin moved with no-change code");
  pwm_force_a: assert property (ok && md == 2'h2 && !io[1] |->
    o_waveform == ((io[0] ~^ c1_q[3]) ^ c1_q[2]))
    else $error("forced level wrong");
endmodule // stm_core_asserts
bind stm_core stm_core_asserts i_stm_core_asserts (.i_core_clk, .i_resetn, .i_addr,
  .i_wdata, .i_wr, .i_rd, .i_external_clock_pin, .o_rdata, .o_waveform, .o_waveform_oe);
`default_nettype wire

// file: test/stm_pin_model.sv
// far side: trigger pulses on the external clock pin
`timescale 1ns/100ps
`default_nettype none
module stm_pin_model (
  input wire i_core_clk,
  input wire i_fire,
  output logic o_pin
);
  reg [2:0] hold_q = 3'h0;
  initial o_pin = 1'b0;
  // pin held a few cycles so the synchroniser sees it
  always @(posedge i_core_clk) begin
    if (i_fire) hold_q <= 3'h4;
    else if (hold_q != 3'h0) hold_q <= hold_q - 3'h1;
    o_pin <= i_fire || hold_q > 3'h1;
  end
endmodule // stm_pin_model
`default_nettype wire

// file: test/tb_stm_core.sv
// self-checking bench for the standard timer
`timescale 1ns/100ps
`default_nettype none
module tb_stm_core;
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg [3:0] addr = 4'h0;
  reg [7:0] wdata = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg fire = 1'b0;
  wire pin;
  wire [7:0] rdata;
  wire wave;
  wire oe;
  integer fails = 0;
  integer check_count = 0;
  integer seed = 19;
  integer i;
  integer n;
  always #5 clk = ~clk;
  stm_core i_stm_core (.i_core_clk(clk), .i_resetn(resetn), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .i_external_clock_pin(pin), .o_rdata(rdata), .o_waveform(wave),
    .o_waveform_oe(oe));
  stm_pin_model i_stm_pin_model (.i_core_clk(clk), .i_fire(fire), .o_pin(pin));
  task results;
    begin
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wreg(input [3:0] a, input [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rreg(input [3:0] a, input [7:0] e);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk({8'h00, rdata}, {8'h00, e});
    end
  endtask
  task idle(input integer c);
    repeat (c) @(posedge clk);
  endtask
  task pin_is(input v);
    #1 chk({15'h0000, wave}, {15'h0000, v});
  endtask
  // high cycles counted over whole periods, so the phase does not matter
  task cnt_hi(input integer c);
    begin
      n = 0;
      repeat (c) begin
        @(posedge clk);
        #1 n = n + (wave === 1'b1);
      end
    end
  endtask
  function exp_pin(input [1:0] io, input oc);
    exp_pin = (io == 2'h0) ? oc : (io == 2'h1) ? 1'b0 : (io == 2'h2) ? 1'b1 : ~oc;
  endfunction
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    for (i = 0; i < 16; i = i + 1) rreg(i[3:0], 8'h00);
    for (i = 0; i < 8; i = i + 1) begin
      n = $random(seed);
      wreg(4'h1, n[7:0]);
      rreg(4'h1, n[7:0]);
    end
    // compare A kept nonzero in compare mode
    wreg(4'h2, 8'h0A);
    wreg(4'h3, 8'h00);
    wreg(4'h4, 8'h01);
    for (i = 0; i < 4; i = i + 1) begin
      wreg(4'h1, {2'b00, i[1:0], ~i[1], 3'b000});
      wreg(4'h7, 8'h03);
      wreg(4'h0, 8'h08);
      idle(2);
      pin_is(~i[1]);
      idle(100);
      pin_is(exp_pin(i[1:0], ~i[1]));
      rreg(4'h7, 8'h01);
      idle(300);
      rreg(4'h7, 8'h03);
      wreg(4'h0, 8'h00);
    end
    wreg(4'h1, 8'h01);
    wreg(4'h7, 8'h03);
    wreg(4'h0, 8'h08);
    idle(600);
    wreg(4'h0, 8'h00);
    rreg(4'h7, 8'h01);
    rreg(4'h6, 8'h00);
    wreg(4'h1, 8'hC1);
    wreg(4'h7, 8'h03);
    wreg(4'h0, 8'h08);
    idle(50);
    #1 chk({15'h0000, oe}, 16'h0000);
    rreg(4'h7, 8'h01);
    wreg(4'h0, 8'h00);
    wreg(4'h2, 8'h40);
    for (i = 0; i < 3; i = i + 1) begin
      wreg(4'h1, (i == 2) ? 8'h88 : {5'h15, i[0], 2'b00});
      wreg(4'h7, 8'h03);
      wreg(4'h0, 8'h08);
      idle(300);
      rreg(4'h7, 8'h03);
      cnt_hi(512);
      chk(n[15:0], (i == 2) ? 16'h0000 : i[0] ? 16'd384 : 16'd128);
      wreg(4'h0, 8'h00);
    end
    wreg(4'h2, 8'h63);
    wreg(4'h4, 8'h00);
    wreg(4'h1, 8'hAA);
    wreg(4'h0, 8'h08);
    idle(50);
    cnt_hi(200);
    chk(n[15:0], 16'd200);
    wreg(4'h0, 8'h00);
    wreg(4'h2, 8'h14);
    wreg(4'h1, 8'hB8);
    for (i = 0; i < 2; i = i + 1) begin
      wreg(4'h7, 8'h03);
      @(posedge clk);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      idle(4);
      pin_is(1'b1);
      idle(60);
      pin_is(1'b0);
      rreg(4'h0, 8'h00);
      rreg(4'h7, 8'h01);
    end
    // run held by software, then dropped before compare A
    wreg(4'h0, 8'h08);
    idle(2);
    pin_is(1'b1);
    wreg(4'h0, 8'h00);
    idle(3);
    pin_is(1'b0);
    results;
  end
  initial begin
    #500000;
    fails = fails + 1;
    results;
  end
endmodule // tb_stm_core
`default_nettype wire
